// file: dcs_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R01: writing 81 resets the device, which comes back halted in debug mode
// R02: writing 41 resets the device, which then resumes normal execution
// R03: in debug mode, writing 40 releases the cpu to run
// R04: debug bit 7 set stops instruction fetch; clearing it resumes execution
// R05: enabled break sets debug bit unless break-loop bit 4 makes cpu loop
// R06: breakpoint enable bit 6 resets low; low makes break a no-operation
// R07: ack bit 5 sends FF on a breakpoint, then clears itself once sent
// R08: pc-match bit 3 sets debug bit when pc equals debug counter
// R09: with pc-match set the debug counter holds while the cpu runs
// R10: zero-count bit 2 sets debug bit when the counter reaches 0000
// R11: with zero-count set the counter is not reset on leaving debug
// R12: reset bit 0 resets the device, not the debugger; clears when done
// R13: host always writes 0 to reserved control bit 1
// R14: idle flag bit 7 shows debug mode or a break since last write
// R15: halt flag bit 6 shows the low-power halt mode
// R16: read-protect flag bit 5 is the inverse of the option bit
// R17: low status bits are reserved and read 0
// R18: baud reload is read-only, 12-bit count, top 4 bits 0, resets 0
// R19: reload count equals system clock over baud rate times 8
// R20: command 04 plus a byte writes control; command 05 reads it
// R21: command 02 returns the status byte
// R22: command 1B returns baud reload, high byte then low byte
// R23: counter decrements once per clock while running outside debug
//////////////////////////////////////////////////////////////////////////////
package dcs_pkg;
	// host command codes
	localparam logic [7:0] CMD_WR_CNT  = 8'h01;
	localparam logic [7:0] CMD_RD_STAT = 8'h02;
	localparam logic [7:0] CMD_RD_CNT  = 8'h03;
	localparam logic [7:0] CMD_WR_CTL  = 8'h04;
	localparam logic [7:0] CMD_RD_CTL  = 8'h05;
	localparam logic [7:0] CMD_RD_BAUD = 8'h1B;
	// control field positions
	localparam int CTL_DBG   = 7;
	localparam int CTL_BREAKPOINT_ENABLE = 6;
	localparam int CTL_ACK   = 5;
	localparam int CTL_LOOP  = 4;
	localparam int CTL_PC    = 3;
	localparam int CTL_ZERO  = 2;
	localparam int CTL_RSV   = 1;
	localparam int CTL_RST   = 0;
	// reset values and constants
	localparam logic [7:0]  CTL_RESET  = 8'h00;
	localparam logic [15:0] CNT_RESET  = 16'h0000;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CNT_NODBG  = 16'hFFFF;
	localparam logic [7:0]  ACK_BYTE   = 8'hFF;
	localparam logic [4:0]  STAT_RSV   = 5'h00;
	localparam logic [3:0]  BAUD_RSV   = 4'h0;
	localparam int          BAUD_W     = 12;
	localparam int          BAUD_BITS  = 8;
	typedef enum logic [1:0] {DCS_IDLE, DCS_CTL, DCS_CNT_H, DCS_CNT_L} dcs_state_t;
endpackage : dcs_pkg

// file: dcs_debug_ctl.sv
`timescale 1ns/1ps
module dcs_debug_ctl (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        tx_ready,
	input  wire logic [15:0] cpu_pc,
	input  wire logic        cpu_brk_decoded,
	input  wire logic        cpu_halt_mode,
	input  wire logic        rp_option_bit,
	input  wire logic        sys_reset_done,
	input  wire logic        debug_serial_pin,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             cpu_stop_fetch,
	output logic             cpu_brk_loop,
	output logic             sys_reset_req
);
	//////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0]               ctl_reg;
	logic [7:0]               ctl_next;
	logic [15:0]              cnt_reg;
	logic [15:0]              cnt_next;
	logic                     brk_seen_reg;
	logic                     loop_reg;
	logic                     ack_pend_reg;
	logic                     ack_busy_reg;
	logic [7:0]               hold_reg;
	logic [7:0]               tx_data_reg;
	logic                     tx_valid_reg;
	logic                     hold_vld_reg;
	logic [7:0]               cnt_hi_reg;
	dcs_pkg::dcs_state_t      state_reg;
	dcs_pkg::dcs_state_t      state_next;
	logic                     pin_s1_reg;
	logic                     pin_s2_reg;
	logic                     pin_d_reg;
	logic                     ab_meas_reg;
	logic                     ab_done_reg;
	logic [dcs_pkg::BAUD_W-1:0] ab_cnt_reg;
	logic [dcs_pkg::BAUD_W-1:0] reload_reg;

	//////////////////////////////////////////////////////////////////////////
	// decode of host bytes and cpu events
	wire idle_st   = (state_reg == dcs_pkg::DCS_IDLE);
	wire tx_free   = !tx_valid_reg || tx_ready;
	wire tx_room   = tx_free && !hold_vld_reg;
	wire cmd_ok    = rx_valid && idle_st && tx_room;
	wire wr_ctl    = rx_valid && (state_reg == dcs_pkg::DCS_CTL);
	wire wr_cnt_l  = rx_valid && (state_reg == dcs_pkg::DCS_CNT_L);
	wire dbg       = ctl_reg[dcs_pkg::CTL_DBG];
	wire running   = !dbg && !ctl_reg[dcs_pkg::CTL_RST];
	wire brk_on    = cpu_brk_decoded && ctl_reg[dcs_pkg::CTL_BREAKPOINT_ENABLE];
	wire brk_stop  = brk_on && !ctl_reg[dcs_pkg::CTL_LOOP];
	wire pc_hit    = running && ctl_reg[dcs_pkg::CTL_PC] && (cpu_pc == cnt_reg);
	wire zero_hit  = running && ctl_reg[dcs_pkg::CTL_ZERO] && (cnt_reg == dcs_pkg::CNT_ZERO);
	wire dbg_set   = brk_stop || pc_hit || zero_hit;
	wire bp_event  = brk_on || pc_hit || zero_hit;
	wire ack_sent  = ack_busy_reg && tx_valid_reg && tx_ready;
	wire leave_dbg = dbg && !ctl_next[dcs_pkg::CTL_DBG];
	// judged on the value being written: the leaving write itself may set the break mode
	wire keep_cnt  = ctl_next[dcs_pkg::CTL_ZERO] || ctl_next[dcs_pkg::CTL_PC];
	wire cnt_dec   = running && !ctl_reg[dcs_pkg::CTL_PC] && !zero_hit;
	wire [7:0] stat_byte = {dbg || brk_seen_reg, cpu_halt_mode, !rp_option_bit,
		dcs_pkg::STAT_RSV};
	wire [15:0] baud_word = {dcs_pkg::BAUD_RSV, reload_reg};
	wire [15:0] cnt_rd    = dbg ? ~cnt_reg : dcs_pkg::CNT_NODBG;

	//////////////////////////////////////////////////////////////////////////
	// control register next value; hardware sets win over host clears
	always_comb
	begin
		ctl_next = ctl_reg;
		if (wr_ctl)
			ctl_next = rx_data; // R01 R02 R03 R13
		if (dbg_set)
			ctl_next[dcs_pkg::CTL_DBG] = 1'b1; // R05 R08 R10
		if (ack_sent && !wr_ctl)
			ctl_next[dcs_pkg::CTL_ACK] = 1'b0; // R07
		if (sys_reset_done && !wr_ctl)
			ctl_next[dcs_pkg::CTL_RST] = 1'b0; // R12
	end

	// debug counter next value
	always_comb
	begin
		cnt_next = cnt_reg;
		if (wr_cnt_l && dbg)
			cnt_next = {cnt_hi_reg, rx_data};
		else if (leave_dbg && !keep_cnt)
			cnt_next = dcs_pkg::CNT_RESET; // R11
		else if (cnt_dec)
			cnt_next = cnt_reg - 16'h0001; // R09 R23
	end

	// command sequencer
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			dcs_pkg::DCS_IDLE:
			begin
				if (cmd_ok && rx_data == dcs_pkg::CMD_WR_CTL)
					state_next = dcs_pkg::DCS_CTL; // R20
				else if (cmd_ok && rx_data == dcs_pkg::CMD_WR_CNT)
					state_next = dcs_pkg::DCS_CNT_H;
			end
			dcs_pkg::DCS_CTL:
				if (rx_valid)
					state_next = dcs_pkg::DCS_IDLE;
			dcs_pkg::DCS_CNT_H:
				if (rx_valid)
					state_next = dcs_pkg::DCS_CNT_L;
			dcs_pkg::DCS_CNT_L:
				if (rx_valid)
					state_next = dcs_pkg::DCS_IDLE;
			default:
				state_next = dcs_pkg::DCS_IDLE;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// registers kept across device reset; only rst_n clears the debugger
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_reg    <= dcs_pkg::CTL_RESET; // R06
			cnt_reg    <= dcs_pkg::CNT_RESET;
			state_reg  <= dcs_pkg::DCS_IDLE;
			cnt_hi_reg <= 8'h00;
		end
		else
		begin
			ctl_reg   <= ctl_next; // R04
			cnt_reg   <= cnt_next;
			state_reg <= state_next;
			if (rx_valid && state_reg == dcs_pkg::DCS_CNT_H)
				cnt_hi_reg <= rx_data;
		end
	end

	// break bookkeeping; a break in the write cycle stays seen
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			brk_seen_reg <= 1'b0;
			loop_reg     <= 1'b0;
		end
		else
		begin
			if (brk_on)
				brk_seen_reg <= 1'b1; // R14
			else if (wr_ctl)
				brk_seen_reg <= 1'b0;
			if (brk_on && ctl_reg[dcs_pkg::CTL_LOOP])
				loop_reg <= 1'b1; // R05
			else if (wr_ctl || !ctl_reg[dcs_pkg::CTL_BREAKPOINT_ENABLE])
				loop_reg <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// reply path: one output register plus one hold byte for two-byte replies
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_valid_reg <= 1'b0;
			tx_data_reg  <= 8'h00;
			hold_vld_reg <= 1'b0;
			hold_reg     <= 8'h00;
			ack_pend_reg <= 1'b0;
			ack_busy_reg <= 1'b0;
		end
		else
		begin
			if (tx_free)
			begin
				tx_valid_reg <= 1'b0;
				ack_busy_reg <= 1'b0;
				if (hold_vld_reg)
				begin
					tx_valid_reg <= 1'b1;
					tx_data_reg  <= hold_reg;
					hold_vld_reg <= 1'b0;
				end
				else if (cmd_ok && rx_data == dcs_pkg::CMD_RD_STAT)
				begin
					tx_valid_reg <= 1'b1;
					tx_data_reg  <= stat_byte; // R15 R16 R17 R21
				end
				else if (cmd_ok && rx_data == dcs_pkg::CMD_RD_CTL)
				begin
					tx_valid_reg <= 1'b1;
					tx_data_reg  <= ctl_reg; // R20
				end
				else if (cmd_ok && rx_data == dcs_pkg::CMD_RD_BAUD)
				begin
					tx_valid_reg <= 1'b1;
					tx_data_reg  <= baud_word[15:8]; // R22
					hold_reg     <= baud_word[7:0];
					hold_vld_reg <= 1'b1;
				end
				else if (cmd_ok && rx_data == dcs_pkg::CMD_RD_CNT)
				begin
					tx_valid_reg <= 1'b1;
					tx_data_reg  <= cnt_rd[15:8];
					hold_reg     <= cnt_rd[7:0];
					hold_vld_reg <= 1'b1;
				end
				else if (ack_pend_reg && idle_st && !rx_valid)
				begin
					tx_valid_reg <= 1'b1;
					tx_data_reg  <= dcs_pkg::ACK_BYTE; // R07
					ack_busy_reg <= 1'b1;
					ack_pend_reg <= 1'b0;
				end
			end
			// placed last so a breakpoint in the send cycle is not lost
			if (bp_event && ctl_reg[dcs_pkg::CTL_ACK])
				ack_pend_reg <= 1'b1; // R07
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// autobaud: the low run of a 80h frame spans 8 bit times, so the count
	// of low cycles is clock over baud times 8; saturates rather than wraps
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_reg  <= 1'b1;
			pin_s2_reg  <= 1'b1;
			pin_d_reg   <= 1'b1;
			ab_meas_reg <= 1'b0;
			ab_done_reg <= 1'b0;
			ab_cnt_reg  <= '0;
			reload_reg  <= '0; // R18
		end
		else
		begin
			pin_s1_reg <= debug_serial_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_d_reg  <= pin_s2_reg;
			if (!ab_done_reg && !ab_meas_reg && pin_d_reg && !pin_s2_reg)
			begin
				ab_meas_reg <= 1'b1;
				ab_cnt_reg  <= {{(dcs_pkg::BAUD_W-1){1'b0}}, 1'b1};
			end
			else if (ab_meas_reg && !pin_s2_reg && !(&ab_cnt_reg))
				ab_cnt_reg <= ab_cnt_reg + 1'b1; // R19
			else if (ab_meas_reg && pin_s2_reg)
			begin
				ab_meas_reg <= 1'b0;
				ab_done_reg <= 1'b1;
				reload_reg  <= ab_cnt_reg; // R18 R19
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign tx_valid       = tx_valid_reg;
	assign tx_data        = tx_data_reg;
	assign cpu_stop_fetch = ctl_reg[dcs_pkg::CTL_DBG]; // R04
	assign cpu_brk_loop   = loop_reg;
	assign sys_reset_req  = ctl_reg[dcs_pkg::CTL_RST]; // R12

	//////////////////////////////////////////////////////////////////////////
	// checks
	a_write_stop: assert property (@(posedge mclk) disable iff (!rst_n) // R01
		wr_ctl && rx_data == 8'h81 |=> cpu_stop_fetch && sys_reset_req)
		else $error("reset-and-stop write not taken");
	a_write_go: assert property (@(posedge mclk) disable iff (!rst_n) // R02
		wr_ctl && rx_data == 8'h41 && !dbg_set |=> !cpu_stop_fetch && sys_reset_req)
		else $error("reset-and-go write not taken");
	a_run_release: assert property (@(posedge mclk) disable iff (!rst_n) // R03
		wr_ctl && rx_data == 8'h40 && !dbg_set |=> !cpu_stop_fetch)
		else $error("run write did not release cpu");
	a_brk_nop: assert property (@(posedge mclk) disable iff (!rst_n) // R06
		cpu_brk_decoded && !ctl_reg[dcs_pkg::CTL_BREAKPOINT_ENABLE] && !pc_hit && !zero_hit
		&& !wr_ctl && !dbg |=> !cpu_stop_fetch && $stable(brk_seen_reg))
		else $error("disabled break had an effect");
	a_brk_stop: assert property (@(posedge mclk) disable iff (!rst_n) // R05
		brk_stop |=> cpu_stop_fetch && !$rose(cpu_brk_loop))
		else $error("break did not enter debug");
	a_pc_match: assert property (@(posedge mclk) disable iff (!rst_n) // R08
		running && ctl_reg[dcs_pkg::CTL_PC] && cpu_pc == cnt_reg |=> cpu_stop_fetch)
		else $error("pc match missed");
	a_pc_hold: assert property (@(posedge mclk) disable iff (!rst_n) // R09
		running && ctl_reg[dcs_pkg::CTL_PC] && !wr_cnt_l |=> $stable(cnt_reg))
		else $error("counter moved in pc match mode");
	a_zero_brk: assert property (@(posedge mclk) disable iff (!rst_n) // R10
		running && ctl_reg[dcs_pkg::CTL_ZERO] && cnt_reg == 16'h0000 |=> cpu_stop_fetch)
		else $error("zero count break missed");
	a_count_down: assert property (@(posedge mclk) disable iff (!rst_n) // R23
		cnt_dec && !wr_ctl |=> cnt_reg == $past(cnt_reg) - 16'h0001)
		else $error("counter did not decrement");
	a_ack_clear: assert property (@(posedge mclk) disable iff (!rst_n) // R07
		ack_sent && !wr_ctl && !ack_pend_reg |=> !ctl_reg[dcs_pkg::CTL_ACK] && !ack_busy_reg)
		else $error("ack enable not cleared");
	a_stat_low: assert property (@(posedge mclk) disable iff (!rst_n) // R17
		cmd_ok && rx_data == 8'h02 |=> tx_valid && tx_data[4:0] == 5'h00)
		else $error("status reserved bits nonzero");
endmodule : dcs_debug_ctl

// file: dcs_host_model.sv
`timescale 1ns/1ps
module dcs_host_model (
	input  wire logic       mclk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            tx_ready
);
	logic       slow;
	logic [7:0] got[$];
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
		slow = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// collect reply bytes; slow mode stalls to stress the held reply
	always @(posedge mclk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		#1 tx_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
	end
	// one byte as a one-cycle pulse; idle data shows the inverse, not a stale copy
	task automatic send(input logic [7:0] b);
		@(posedge mclk);
		#1 rx_valid = 1'b1;
		rx_data = b;
		@(posedge mclk);
		#1 rx_valid = 1'b0;
		rx_data = ~b;
	endtask : send
	// control write keeps the reserved bit low
	task automatic wr_ctl(input logic [7:0] d);
		send(8'h04);
		send(d & 8'hFD);
	endtask : wr_ctl
endmodule : dcs_host_model

// file: dcs_debug_ctl_bench.sv
`timescale 1ns/1ps
module dcs_debug_ctl_bench;
	logic        mclk, rst_n, rx_valid, tx_ready, tx_valid, break_instruction, halt, rp, done, pin;
	logic        cpu_stop_fetch, cpu_brk_loop, sys_reset_req;
	logic [7:0]  rx_data, tx_data;
	logic [15:0] cpu_pc, v, p;
	int          err_total, compares, i;
	dcs_debug_ctl uut (.mclk(mclk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_ready(tx_ready), .cpu_pc(cpu_pc), .cpu_brk_decoded(break_instruction), .cpu_halt_mode(halt),
		.rp_option_bit(rp), .sys_reset_done(done), .debug_serial_pin(pin),
		.tx_valid(tx_valid), .tx_data(tx_data), .cpu_stop_fetch(cpu_stop_fetch),
		.cpu_brk_loop(cpu_brk_loop), .sys_reset_req(sys_reset_req));
	dcs_host_model host (.mclk(mclk), .tx_valid(tx_valid), .tx_data(tx_data),
		.rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	// bounded wait so a lost reply cannot hang the run
	task automatic wait_rx(input int n);
		for (int k = 0; k < 60 && host.got.size() < n; k++)
			tick(1);
	endtask : wait_rx
	task automatic rd(input logic [7:0] c, input int n, output logic [15:0] r);
		host.got.delete();
		host.send(c);
		wait_rx(n);
		r = (n == 2) ? {host.got[0], host.got[1]} : {8'h00, host.got[0]};
	endtask : rd
	task automatic wr(input logic [7:0] d);
		host.wr_ctl(d);
		tick(2);
	endtask : wr
	task automatic wr_cnt(input logic [15:0] c);
		host.send(8'h01);
		host.send(c[15:8]);
		host.send(c[7:0]);
	endtask : wr_cnt
	task automatic pulse_brk();
		break_instruction = 1'b1;
		tick(1);
		break_instruction = 1'b0;
		tick(2);
	endtask : pulse_brk
	task automatic pulse_done();
		done = 1'b1;
		tick(1);
		done = 1'b0;
		tick(2);
	endtask : pulse_done
	function automatic logic [15:0] stat_exp(input logic idle);
		return {8'h00, idle, halt, ~rp, 5'h00};
	endfunction : stat_exp
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////
	// watchdog: the tests need well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_total++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h6258));
		{rst_n, break_instruction, halt, done, cpu_pc} = '0;
		{rp, pin} = 2'b11;
		err_total = 0;
		compares = 0;
		repeat (12) @(posedge mclk);
		#1 rst_n = 1'b1;
		chk("stop", 16'h0000, {15'h0, cpu_stop_fetch});
		rd(8'h05, 1, v);
		chk("control", 16'h0000, v);
		// 80h character: start plus seven zero bits, 25 cycles each
		pin = 1'b0;
		tick(200);
		pin = 1'b1;
		tick(5);
		rd(8'h1B, 2, v);
		chk("reload", 16'h00C8, v);
		$display("test reset and autobaud done");
		for (i = 0; i < 6; i++)
		begin
			halt = 1'($urandom);
			rp = 1'($urandom);
			tick(1);
			rd(8'h02, 1, v);
			chk("status", stat_exp(1'b0), v);
		end
		wr(8'h81);
		chk("stop", 16'h0001, {15'h0, cpu_stop_fetch});
		chk("rstreq", 16'h0001, {15'h0, sys_reset_req});
		pulse_done();
		chk("rstreq", 16'h0000, {15'h0, sys_reset_req});
		rd(8'h05, 1, v);
		chk("control", 16'h0080, v);
		rd(8'h02, 1, v);
		chk("status", stat_exp(1'b1), v);
		wr(8'h40);
		chk("stop", 16'h0000, {15'h0, cpu_stop_fetch});
		rd(8'h02, 1, v);
		chk("status", stat_exp(1'b0), v);
		wr(8'h41);
		chk("rstreq", 16'h0001, {15'h0, sys_reset_req});
		pulse_done();
		rd(8'h05, 1, v);
		chk("control", 16'h0040, v);
		$display("test control writes done");
		// break with breakpoints off, then on with ack under a stalling host
		wr(8'h00);
		pulse_brk();
		chk("stop", 16'h0000, {15'h0, cpu_stop_fetch});
		host.slow = 1'b1;
		wr(8'h60);
		host.got.delete();
		pulse_brk();
		wait_rx(1);
		chk("ack", 16'h00FF, {8'h00, host.got[0]});
		chk("stop", 16'h0001, {15'h0, cpu_stop_fetch});
		rd(8'h05, 1, v);
		chk("control", 16'h00C0, v);
		wr(8'h50);
		pulse_brk();
		chk("loop", 16'h0001, {15'h0, cpu_brk_loop});
		chk("stop", 16'h0000, {15'h0, cpu_stop_fetch});
		rd(8'h02, 1, v);
		chk("status", stat_exp(1'b1), v);
		wr(8'h00);
		chk("loop", 16'h0000, {15'h0, cpu_brk_loop});
		host.slow = 1'b0;
		$display("test break handling done");
		// pc match against a random counter value
		wr(8'h80);
		p = 16'($urandom);
		wr_cnt(p);
		cpu_pc = ~p;
		wr(8'h08);
		tick(10);
		chk("stop", 16'h0000, {15'h0, cpu_stop_fetch});
		cpu_pc = p;
		tick(3);
		chk("stop", 16'h0001, {15'h0, cpu_stop_fetch});
		rd(8'h03, 1 + 1, v);
		chk("counter", ~p, v);
		// count down from 20 to zero; counter must survive leaving debug
		wr_cnt(16'd20);
		wr(8'h04);
		chk("stop", 16'h0000, {15'h0, cpu_stop_fetch});
		tick(25);
		chk("stop", 16'h0001, {15'h0, cpu_stop_fetch});
		rd(8'h03, 2, v);
		chk("counter", 16'hFFFF, v);
		$display("test counter breaks done");
		summarize();
	end
endmodule : dcs_debug_ctl_bench
